// File: verilog/orps_pkg.sv
package orps_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clock and array geometry
   localparam int CLK_PERIOD_NS = 50;
   localparam int ADDR_W        = 18;
   localparam int DATA_W        = 8;
   localparam int TMR_W         = 12;
   localparam int SYNC_STAGES   = 2;
   localparam int MAX_RETRY     = 10;

   ////////////////////////////////////////////////////////////////////////////////
   // times as printed, in ns
   localparam int PULSE_NOM_NS = 100000;
   localparam int PULSE_MIN_NS = 95000;
   localparam int PULSE_MAX_NS = 105000;
   localparam int SETUP_NS     = 2000;
   localparam int HOLD_NS      = 2000;
   localparam int SUPPLY_NS    = 2000;
   localparam int FLOAT_NS     = 130;
   localparam int OE_VALID_NS  = 150;

   ////////////////////////////////////////////////////////////////////////////////
   // cycle counts; least times round up, nominal pulse sits inside min..max
   localparam logic [TMR_W-1:0] PULSE_CYC  = TMR_W'(PULSE_NOM_NS / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] SETUP_CYC  =
      TMR_W'((SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1);
   localparam logic [TMR_W-1:0] HOLD_CYC   =
      TMR_W'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] SUPPLY_CYC =
      TMR_W'((SUPPLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] FLOAT_CYC  =
      TMR_W'((FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] READ_CYC   =
      TMR_W'((OE_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES + 1);
   localparam logic [3:0]       RETRY_LAST = 4'(MAX_RETRY);

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer states and phases
   typedef enum logic [4:0] {
      sIdle, sVccUp, sVppUp, sFloat, sProgSetup, sPulse, sProgHold,
      sRead, sCheck, sVppDown, sVccDown, sIdEnter, sIdExit, sDone
   } orps_state_type;

   typedef enum logic [1:0] {
      mProg, mVerify, mFinal, mId
   } orps_mode_type;

endpackage

// File: verilog/orps_timer.sv
`timescale 1ns/1ns
// one-shot down counter: expired lands so the caller's state lasts exactly load cycles
module orps_timer
   import orps_pkg::*;
#(
   parameter int W = orps_pkg::TMR_W
)
(
   // clock and reset
   input  wire logic         clock,
   input  wire logic         nrst,
   // control
   input  wire logic         start,
   input  wire logic [W-1:0] load,
   // status
   output logic              expired
);

   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;
   logic         run_r;
   logic         run_nxt;
   logic         expired_r;
   logic         expired_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // a restart while running simply reloads, so the fsm never sees a stale expiry
   always_comb
   begin
      count_nxt   = count_r;
      run_nxt     = run_r;
      expired_nxt = 1'b0;
      if (start)
      begin
         // one less, since the expiry flop adds a cycle of its own
         count_nxt = load - W'(1);
         run_nxt   = 1'b1;
      end
      else if (run_r)
      begin
         count_nxt = count_r - W'(1);
         if (count_r == W'(1))
         begin
            run_nxt     = 1'b0;
            expired_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         count_r   <= '0;
         run_r     <= 1'b0;
         expired_r <= 1'b0;
      end
      else
      begin
         count_r   <= count_nxt;
         run_r     <= run_nxt;
         expired_r <= expired_nxt;
      end
   end

   assign expired = expired_r;

endmodule

// File: verilog/orps_sequencer.sv
`timescale 1ns/1ns
// programmer-side sequencer for a 256k x 8 otp memory
module orps_sequencer
   import orps_pkg::*;
(
   // clock and reset
   input  wire logic                         clock,
   input  wire logic                         nrst,
   // user commands
   input  wire logic                         startProg,
   input  wire logic                         startId,
   // source image lookup
   output logic [orps_pkg::ADDR_W-1:0]       srcAddr,
   input  wire logic [orps_pkg::DATA_W-1:0]  srcData,
   // user status
   output logic                              busy,
   output logic                              done,
   output logic                              pass,
   output logic                              fail,
   output logic [orps_pkg::DATA_W-1:0]       idMfrCode,
   output logic [orps_pkg::DATA_W-1:0]       idDevCode,
   // memory pins
   output logic [orps_pkg::ADDR_W-1:0]       devAddr,
   output logic [orps_pkg::DATA_W-1:0]       devDataOut,
   output logic                              devDataOe_n,
   input  wire logic [orps_pkg::DATA_W-1:0]  devDataIn,
   output logic                              chipSel_n,
   output logic                              outEn_n,
   output logic                              program_strobe_n,
   output logic                              vccProgHigh,
   output logic                              vppProgHigh,
   output logic                              addressBitNineHv
);

   orps_state_type          st_r;
   orps_state_type          stNxt;
   orps_mode_type           mode_r;
   orps_mode_type           modeNxt;
   logic [ADDR_W-1:0]       addr_r;
   logic [ADDR_W-1:0]       addr_nxt;
   logic [3:0]              retry_r;
   logic [3:0]              retry_nxt;
   logic                    failed_r;
   logic                    failed_nxt;
   logic [DATA_W-1:0]       mfr_r;
   logic [DATA_W-1:0]       mfr_nxt;
   logic [DATA_W-1:0]       dev_r;
   logic [DATA_W-1:0]       dev_nxt;
   logic [DATA_W-1:0]       sync1_r;
   logic [DATA_W-1:0]       sync2_r;
   logic                    tmrStart;
   logic [TMR_W-1:0]        tmrLoad;
   logic                    tmrDone;
   logic                    lastAddr;
   logic                    match;
   // registered pin and status images
   logic [DATA_W-1:0]       dout_r;
   logic [DATA_W-1:0]       dout_nxt;
   logic                    doe_n_r;
   logic                    doe_n_nxt;
   logic                    ce_n_r;
   logic                    ce_n_nxt;
   logic                    oe_n_r;
   logic                    oe_n_nxt;
   logic                    pgm_n_r;
   logic                    pgm_n_nxt;
   logic                    vcc_r;
   logic                    vcc_nxt;
   logic                    vpp_r;
   logic                    vpp_nxt;
   logic                    hv_r;
   logic                    hv_nxt;
   logic                    busy_r;
   logic                    busy_nxt;
   logic                    done_r;
   logic                    done_nxt;
   logic                    pass_r;
   logic                    pass_nxt;
   logic                    fail_r;
   logic                    fail_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // read data arrives from pins, so it is synchronised before comparison
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= devDataIn;
         sync2_r <= sync1_r;
      end
   end

   assign lastAddr = (addr_r == {ADDR_W{1'b1}});
   assign match    = (sync2_r == srcData);

   ////////////////////////////////////////////////////////////////////////////////
   // shared interval timer for pulses, setups and read waits
   orps_timer #(
      .W       (TMR_W)
   ) u_timer (
      .clock   (clock),
      .nrst    (nrst),
      .start   (tmrStart),
      .load    (tmrLoad),
      .expired (tmrDone)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // sequencer next state
   always_comb
   begin
      stNxt      = st_r;
      modeNxt    = mode_r;
      addr_nxt   = addr_r;
      retry_nxt  = retry_r;
      failed_nxt = failed_r;
      mfr_nxt    = mfr_r;
      dev_nxt    = dev_r;
      pass_nxt   = pass_r;
      fail_nxt   = fail_r;
      done_nxt   = 1'b0;
      case (st_r)
         sIdle:
         begin
            if (startProg)
            begin
               addr_nxt   = '0;
               modeNxt    = mProg;
               retry_nxt  = '0;
               failed_nxt = 1'b0;
               pass_nxt   = 1'b0;
               fail_nxt   = 1'b0;
               stNxt      = sVccUp;
            end
            else if (startId)
            begin
               addr_nxt = '0;
               modeNxt  = mId;
               stNxt    = sIdEnter;
            end
         end
         // core supply first, programming supply after it
         sVccUp:     if (tmrDone) stNxt = sVppUp;
         sVppUp:     if (tmrDone) stNxt = sProgSetup;
         sFloat:     if (tmrDone) stNxt = sProgSetup;
         sProgSetup: if (tmrDone) stNxt = sPulse;
         sPulse:     if (tmrDone) stNxt = sProgHold;
         sProgHold:
         begin
            if (tmrDone)
            begin
               if (mode_r == mProg)
               begin
                  // first pass: no read between pulses
                  if (lastAddr)
                  begin
                     addr_nxt = '0;
                     modeNxt  = mVerify;
                     stNxt    = sRead;
                  end
                  else
                  begin
                     addr_nxt = addr_r + ADDR_W'(1);
                     stNxt    = sProgSetup;
                  end
               end
               else
               begin
                  stNxt = sRead;
               end
            end
         end
         sRead:      if (tmrDone) stNxt = sCheck;
         sCheck:
         begin
            case (mode_r)
               mVerify:
               begin
                  if (match)
                  begin
                     retry_nxt = '0;
                     if (lastAddr)
                        stNxt = sVppDown;
                     else
                     begin
                        addr_nxt = addr_r + ADDR_W'(1);
                        stNxt    = sRead;
                     end
                  end
                  else if (retry_r == RETRY_LAST)
                  begin
                     failed_nxt = 1'b1;
                     stNxt      = sVppDown;
                  end
                  else
                  begin
                     retry_nxt = retry_r + 4'h1;
                     stNxt     = sFloat;
                  end
               end
               mFinal:
               begin
                  if (!match)
                     failed_nxt = 1'b1;
                  if (lastAddr)
                     stNxt = sDone;
                  else
                  begin
                     addr_nxt = addr_r + ADDR_W'(1);
                     stNxt    = sRead;
                  end
               end
               mId:
               begin
                  if (!addr_r[0])
                  begin
                     mfr_nxt  = sync2_r;
                     addr_nxt = {{(ADDR_W-1){1'b0}}, 1'b1};
                     stNxt    = sRead;
                  end
                  else
                  begin
                     dev_nxt = sync2_r;
                     stNxt   = sIdExit;
                  end
               end
               default: stNxt = sIdle;
            endcase
         end
         // programming supply drops first so it never exceeds the core supply
         sVppDown:   if (tmrDone) stNxt = sVccDown;
         sVccDown:
         begin
            if (tmrDone)
            begin
               if (failed_r)
                  stNxt = sDone;
               else
               begin
                  addr_nxt = '0;
                  modeNxt  = mFinal;
                  stNxt    = sRead;
               end
            end
         end
         sIdEnter:   if (tmrDone) stNxt = sRead;
         sIdExit:    if (tmrDone) stNxt = sDone;
         sDone:
         begin
            done_nxt = 1'b1;
            if (mode_r != mId)
            begin
               pass_nxt = !failed_r;
               fail_nxt = failed_r;
            end
            stNxt = sIdle;
         end
         default: stNxt = sIdle;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // timer reload on every entry into a timed state
   always_comb
   begin
      tmrLoad  = SETUP_CYC;
      case (stNxt)
         sVccUp, sVppUp, sVppDown, sVccDown, sIdExit: tmrLoad = SUPPLY_CYC;
         sFloat:    tmrLoad = FLOAT_CYC;
         sPulse:    tmrLoad = PULSE_CYC;
         sProgHold: tmrLoad = HOLD_CYC;
         sRead:     tmrLoad = READ_CYC;
         default:   tmrLoad = SETUP_CYC;
      endcase
      tmrStart = (stNxt != st_r) &&
                 (stNxt != sIdle) && (stNxt != sCheck) && (stNxt != sDone);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin images follow the next state, so the strobe is low for exactly the pulse count
   always_comb
   begin
      ce_n_nxt  = (stNxt == sIdle) || (stNxt == sDone);
      pgm_n_nxt = (stNxt != sPulse);
      oe_n_nxt  = !((stNxt == sRead) || (stNxt == sCheck));
      doe_n_nxt = !((stNxt == sProgSetup) || (stNxt == sPulse) || (stNxt == sProgHold));
      dout_nxt  = doe_n_nxt ? dout_r : srcData;
      vcc_nxt   = vcc_r;
      vpp_nxt   = vpp_r;
      hv_nxt    = hv_r;
      busy_nxt  = (stNxt != sIdle);
      case (stNxt)
         sVccUp:   vcc_nxt = 1'b1;
         sVppUp:   vpp_nxt = 1'b1;
         sVppDown: vpp_nxt = 1'b0;
         sVccDown: vcc_nxt = 1'b0;
         sIdEnter: hv_nxt  = 1'b1;
         sIdExit:  hv_nxt  = 1'b0;
         sIdle:
         begin
            vcc_nxt = 1'b0;
            vpp_nxt = 1'b0;
            hv_nxt  = 1'b0;
         end
         default:  hv_nxt  = hv_r;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         st_r     <= sIdle;
         mode_r   <= mProg;
         addr_r   <= '0;
         retry_r  <= '0;
         failed_r <= 1'b0;
         mfr_r    <= '0;
         dev_r    <= '0;
         dout_r   <= '0;
         doe_n_r  <= 1'b1;
         ce_n_r   <= 1'b1;
         oe_n_r   <= 1'b1;
         pgm_n_r  <= 1'b1;
         vcc_r    <= 1'b0;
         vpp_r    <= 1'b0;
         hv_r     <= 1'b0;
         busy_r   <= 1'b0;
         done_r   <= 1'b0;
         pass_r   <= 1'b0;
         fail_r   <= 1'b0;
      end
      else
      begin
         st_r     <= stNxt;
         mode_r   <= modeNxt;
         addr_r   <= addr_nxt;
         retry_r  <= retry_nxt;
         failed_r <= failed_nxt;
         mfr_r    <= mfr_nxt;
         dev_r    <= dev_nxt;
         dout_r   <= dout_nxt;
         doe_n_r  <= doe_n_nxt;
         ce_n_r   <= ce_n_nxt;
         oe_n_r   <= oe_n_nxt;
         pgm_n_r  <= pgm_n_nxt;
         vcc_r    <= vcc_nxt;
         vpp_r    <= vpp_nxt;
         hv_r     <= hv_nxt;
         busy_r   <= busy_nxt;
         done_r   <= done_nxt;
         pass_r   <= pass_nxt;
         fail_r   <= fail_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs straight from flops
   assign srcAddr          = addr_r;
   assign devAddr          = addr_r;
   assign devDataOut       = dout_r;
   assign devDataOe_n      = doe_n_r;
   assign chipSel_n        = ce_n_r;
   assign outEn_n          = oe_n_r;
   assign program_strobe_n = pgm_n_r;
   assign vccProgHigh      = vcc_r;
   assign vppProgHigh      = vpp_r;
   assign addressBitNineHv = hv_r;
   assign busy             = busy_r;
   assign done             = done_r;
   assign pass             = pass_r;
   assign fail             = fail_r;
   assign idMfrCode        = mfr_r;
   assign idDevCode        = dev_r;

endmodule

// File: verification/orps_monitor.sv
`timescale 1ns/1ns
// protocol watcher on the sequencer pins
module orps_monitor
   import orps_pkg::*;
(
   // clock and reset
   input wire logic              clock,
   input wire logic              nrst,
   // status
   input wire logic              done,
   input wire logic              pass,
   input wire logic              fail,
   // memory pins
   input wire logic [ADDR_W-1:0] devAddr,
   input wire logic              devDataOe_n,
   input wire logic              chipSel_n,
   input wire logic              outEn_n,
   input wire logic              program_strobe_n,
   input wire logic              vccProgHigh,
   input wire logic              vppProgHigh,
   input wire logic              addressBitNineHv
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   logic [11:0]       lowCnt_r, lowCnt_nxt;
   logic [3:0]        pulseCnt_r, pulseCnt_nxt;
   logic [ADDR_W-1:0] lastAddr_r;

   ////////////////////////////////////////////////////////////////////////////////
   // strobe low time and pulses per address; address change restarts the count
   always_comb
   begin
      lowCnt_nxt = program_strobe_n ? 12'h000 : lowCnt_r + 12'h001;
      pulseCnt_nxt = (devAddr != lastAddr_r) ? 4'h0 : pulseCnt_r;
      if (!program_strobe_n && lowCnt_r == 12'h000)
         pulseCnt_nxt = pulseCnt_nxt + 4'h1;
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         lowCnt_r   <= 12'h000;
         pulseCnt_r <= 4'h0;
         lastAddr_r <= '0;
      end
      else
      begin
         lowCnt_r   <= lowCnt_nxt;
         pulseCnt_r <= pulseCnt_nxt;
         lastAddr_r <= devAddr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   a_pulse_width: assert property ($rose(program_strobe_n) |-> lowCnt_r == 12'h7d0)
      else $error("program pulse width wrong");
   a_pulse_supplies: assert property
      (!program_strobe_n |-> vccProgHigh && vppProgHigh && !chipSel_n && !devDataOe_n)
      else $error("pulse without supplies or data");
   a_vpp_after_vcc: assert property ($rose(vppProgHigh) |-> $past(vccProgHigh))
      else $error("vpp raised before vcc");
   a_vcc_after_vpp: assert property ($fell(vccProgHigh) |-> !$past(vppProgHigh))
      else $error("vcc lowered before vpp");
   a_start_addr_zero: assert property ($rose(vccProgHigh) |-> devAddr == '0)
      else $error("run not started at address zero");
   a_read_no_strobe: assert property
      (!outEn_n |-> program_strobe_n && devDataOe_n && !chipSel_n)
      else $error("read with strobe or driven data");
   a_retry_limit: assert property (pulseCnt_r <= 4'ha)
      else $error("too many pulses on one address");
   a_id_voltage: assert property
      (addressBitNineHv |-> !vccProgHigh && !vppProgHigh && program_strobe_n)
      else $error("id voltage during programming");
   a_fail_verdict: assert property ($rose(fail) |-> done && !pass)
      else $error("fail set outside done");
   a_pass_verdict: assert property ($rose(pass) |-> done && !fail)
      else $error("pass set outside done");

   c_pulse_end: cover property ($rose(program_strobe_n));
   c_id_read: cover property (!outEn_n && addressBitNineHv);
   c_run_done: cover property (done);
endmodule

bind orps_sequencer orps_monitor mon_u (.clock, .nrst, .done, .pass, .fail, .devAddr,
   .devDataOe_n, .chipSel_n, .outEn_n, .program_strobe_n, .vccProgHigh, .vppProgHigh,
   .addressBitNineHv);

// File: verification/orps_otp_model.sv
`timescale 1ns/1ns
// behavioural otp array; erased cells read all ones, programming only clears bits
module orps_otp_model
   import orps_pkg::*;
#(
   parameter logic [7:0] MFR_CODE = 8'ha5, // arbitrary value
   parameter logic [7:0] DEV_CODE = 8'h3c  // arbitrary value
)
(
   // control pins
   input wire logic              chipSel_n,
   input wire logic              outEn_n,
   input wire logic              program_strobe_n,
   input wire logic              vppProgHigh,
   input wire logic              addressBitNineHv,
   // address and data
   input wire logic [ADDR_W-1:0] devAddr,
   input wire logic [DATA_W-1:0] devDataOut,
   output logic      [DATA_W-1:0] devDataIn
);
   logic [DATA_W-1:0] mem [int];
   logic [DATA_W-1:0] lastOut = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // byte written at strobe end, only with high programming supply
   always @(posedge program_strobe_n)
      if (!chipSel_n && vppProgHigh)
         mem[devAddr] = (mem.exists(devAddr) ? mem[devAddr] : 8'hff) & devDataOut;

   ////////////////////////////////////////////////////////////////////////////////
   // released pins show the inverted last byte so stale data can never match
   always @(chipSel_n, outEn_n, addressBitNineHv, devAddr)
      if (!chipSel_n && !outEn_n)
      begin
         if (addressBitNineHv)
            devDataIn = devAddr[0] ? DEV_CODE : MFR_CODE;
         else
            devDataIn = mem.exists(devAddr) ? mem[devAddr] : 8'hff;
         lastOut = devDataIn;
      end
      else
         devDataIn = ~lastOut;
endmodule

// File: verification/orps_tb.sv
`timescale 1ns/1ns
module tb;
   import orps_pkg::*;
   localparam logic [7:0] MFR = 8'ha5; // arbitrary value
   localparam logic [7:0] DEV = 8'h3c; // arbitrary value

   logic              clock = 1'b0;
   logic              nrst = 1'b0;
   logic              startProg = 1'b0;
   logic              startId = 1'b0;
   logic [DATA_W-1:0] srcData = 8'h00;
   logic [DATA_W-1:0] devDataIn;
   logic [ADDR_W-1:0] srcAddr, devAddr;
   logic [DATA_W-1:0] idMfrCode, idDevCode, devDataOut;
   logic              busy, done, pass, fail, devDataOe_n, chipSel_n, outEn_n;
   logic              program_strobe_n, vccProgHigh, vppProgHigh, addressBitNineHv;
   logic              sawRead = 1'b0;
   int                n_errors = 0;
   int                checks = 0;

   orps_sequencer dut_u (.clock, .nrst, .startProg, .startId, .srcAddr, .srcData, .busy,
      .done, .pass, .fail, .idMfrCode, .idDevCode, .devAddr, .devDataOut, .devDataOe_n,
      .devDataIn, .chipSel_n, .outEn_n, .program_strobe_n, .vccProgHigh, .vppProgHigh,
      .addressBitNineHv);

   orps_otp_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) otp_u (.chipSel_n, .outEn_n,
      .program_strobe_n, .vppProgHigh, .addressBitNineHv, .devAddr, .devDataOut,
      .devDataIn);

   ////////////////////////////////////////////////////////////////////////////////
   // clock, source image lookup one cycle behind, read watcher
   initial
      forever #25 clock = ~clock;

   function automatic logic [7:0] src(input logic [ADDR_W-1:0] a);
      return a[7:0] ^ 8'h5a;
   endfunction

   always @(posedge clock)
      srcData <= src(srcAddr);

   always @(negedge clock)
      if (outEn_n === 1'b0)
         sawRead <= 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // report, compare and wait helpers
   task automatic end_sim();
      if (n_errors == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[FAIL] %0t %s got %h", $time, what, got);
      end
   endtask

   // selector keeps one bounded wait loop for every condition
   function automatic logic probe(input int k);
      case (k)
         0: return done;
         1: return vccProgHigh;
         2: return !program_strobe_n;
         3: return program_strobe_n;
         default: return !outEn_n;
      endcase
   endfunction

   task automatic wait_on(input int k, input int lim);
      int i;
      for (i = 0; i < lim && probe(k) !== 1'b1; i++)
         @(negedge clock);
      if (probe(k) !== 1'b1)
      begin
         n_errors++;
         $display("[FAIL] %0t wait %0d timed out", $time, k);
         end_sim();
      end
   endtask

   task automatic pulse_start(input logic prog);
      @(posedge clock);
      startProg <= prog;
      startId <= !prog;
      @(posedge clock);
      startProg <= 1'b0;
      startId <= 1'b0;
      @(negedge clock);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_idle();
      @(negedge clock);
      cmp_val(32'({chipSel_n, outEn_n, program_strobe_n, devDataOe_n}), 32'hf, "idle pins");
      cmp_val(32'({busy, vccProgHigh, vppProgHigh, addressBitNineHv}), 32'h0, "idle levels");
   endtask

   task automatic t_id();
      pulse_start(1'b0);
      wait_on(4, 100);
      cmp_val(32'(addressBitNineHv), 32'h1, "id voltage at read");
      wait_on(0, 300);
      cmp_val(32'(idMfrCode), 32'(MFR), "maker byte");
      cmp_val(32'(idDevCode), 32'(DEV), "type byte");
      cmp_val(32'({pass, fail}), 32'h0, "verdict touched by id");
   endtask

   task automatic t_prog();
      int n;
      pulse_start(1'b1);
      wait_on(1, 10);
      cmp_val(32'(devAddr), 32'h0, "first address");
      cmp_val(32'(vppProgHigh), 32'h0, "vpp before vcc");
      sawRead = 1'b0;
      for (int a = 0; a < 3; a++)
      begin
         wait_on(2, 300);
         cmp_val(32'(devAddr), 32'(a), "pulse address order");
         cmp_val(32'(srcAddr), 32'(a), "source address");
         cmp_val(32'(devDataOut), 32'(src(18'(a))), "pulse data");
         cmp_val(32'(vppProgHigh), 32'h1, "vpp in pulse");
         for (n = 0; n < 2200 && program_strobe_n === 1'b0; n++)
            @(negedge clock);
         cmp_val(32'(n), 32'd2000, "pulse width");
         cmp_val(32'(otp_u.mem[a]), 32'(src(18'(a))), "programmed byte");
      end
      cmp_val(32'(sawRead), 32'h0, "read in first pass");
      // start while busy must be ignored
      pulse_start(1'b0);
      repeat (5) @(negedge clock);
      cmp_val(32'({addressBitNineHv, vccProgHigh, busy}), 32'h3, "start taken while busy");
      // reset in mid-run drops supplies at once
      @(posedge clock);
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      cmp_val(32'({chipSel_n, vccProgHigh, vppProgHigh}), 32'h4, "reset in run");
      nrst <= 1'b1;
      t_idle();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      t_idle();
      t_id();
      t_prog();
      t_id();
      end_sim();
   end
endmodule
